// File: dv/erase_cmd_chk.sv
// Port checker for the erase command block.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/10ps
module erase_cmd_chk #(
   parameter SECTOR_ERASE_CYCLES     = 1,
   parameter HALF_BLOCK_ERASE_CYCLES = 1,
   parameter BLOCK_ERASE_CYCLES      = 1
) (
   input wire        clk_sys_in,
   input wire        rst_n_in,
   input wire        deep_power_down_in,
   input wire        write_in_progress_out,
   input wire        write_enable_latch_out,
   input wire        erase_reject_out,
   input wire        erase_start_out,
   input wire [31:0] check_addr_out,
   input wire [31:0] erase_base_addr_out,
   input wire [2:0]  erase_kind_out
);
   logic [31:0] run_reg;
   wire  [31:0] want = (erase_kind_out == 3'h1) ? SECTOR_ERASE_CYCLES :
                       (erase_kind_out == 3'h2) ? HALF_BLOCK_ERASE_CYCLES : BLOCK_ERASE_CYCLES;
   // Busy cycles since the start pulse
   always @(posedge clk_sys_in) begin
      if (!rst_n_in || erase_start_out)
         run_reg <= 32'h0;
      else if (write_in_progress_out)
         run_reg <= run_reg + 32'h1;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   sequence busy_run;
      write_in_progress_out [*8];
   endsequence
   sequence erase_end;
      $fell(write_in_progress_out) && !erase_reject_out;
   endsequence
   pulse_excl_a: assert property (!(erase_start_out && erase_reject_out))
      else $error("start and reject together");
   start_pulse_a: assert property (erase_start_out |=> !erase_start_out)
      else $error("start pulse too long");
   start_busy_a: assert property (erase_start_out |-> write_in_progress_out && $past(write_in_progress_out) && write_enable_latch_out)
      else $error("start without check cycle or latch");
   busy_hold_a: assert property (erase_start_out |=> busy_run)
      else $error("busy dropped early");
   sector_align_a: assert property (erase_start_out && erase_kind_out == 3'h1 |-> erase_base_addr_out[11:0] == 12'h000)
      else $error("sector base misaligned");
   half_align_a: assert property (erase_start_out && erase_kind_out == 3'h2 |-> erase_base_addr_out[14:0] == 15'h0000)
      else $error("half block base misaligned");
   block_align_a: assert property (erase_start_out && erase_kind_out == 3'h4 |-> erase_base_addr_out[15:0] == 16'h0000)
      else $error("block base misaligned");
   kind_onehot_a: assert property (erase_start_out |-> $onehot(erase_kind_out))
      else $error("kind not one-hot");
   addr_match_a: assert property (erase_start_out |-> erase_base_addr_out == check_addr_out)
      else $error("erased base differs from checked address");
   done_latch_a: assert property (erase_end |-> !write_enable_latch_out)
      else $error("latch kept after erase");
   erase_time_a: assert property (erase_end |-> run_reg + 32'h1 >= want && run_reg <= want + 32'h1)
      else $error("erase time wrong");
   sleep_quiet_a: assert property (deep_power_down_in [*3] |-> !erase_start_out && !erase_reject_out)
      else $error("answer in power-down");
endmodule
bind serial_flash_erase_commands erase_cmd_chk #(
   .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
   .HALF_BLOCK_ERASE_CYCLES(HALF_BLOCK_ERASE_CYCLES),
   .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES)
) chk_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .deep_power_down_in(deep_power_down_in),
   .write_in_progress_out(write_in_progress_out), .write_enable_latch_out(write_enable_latch_out),
   .erase_reject_out(erase_reject_out), .erase_start_out(erase_start_out), .check_addr_out(check_addr_out),
   .erase_base_addr_out(erase_base_addr_out), .erase_kind_out(erase_kind_out));

// File: dv/flash_host_model.sv
// Host controller model: sends select-framed bit strings on the serial pins.
// Assumes each call starts just after a system clock edge, select high.
`timescale 1ns/10ps
module flash_host_model (
   // Serial pins
   output logic       cs_n_out,
   output logic       sclk_out,
   output logic [3:0] sio_out
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sio_out  = 4'hA;
   end
   // Link clock stands low outside frames; in quad n must be a multiple of 4
   task automatic send_frame(input logic [39:0] f, input int n, input logic q);
      int i;
      #40 cs_n_out = 1'b0;
      i = n;
      while (i > 0) begin
         if (q) begin
            sio_out = f[i-1 -: 4];
            i -= 4;
         end else begin
            sio_out = {~{3{f[i-1]}}, f[i-1]};
            i -= 1;
         end
         #40 sclk_out = 1'b1;
         #40 sclk_out = 1'b0;
      end
      #40 cs_n_out = 1'b1;
      // Released lines must not keep the last value
      sio_out = ~sio_out;
   endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the erase command block.
// Assumes the host model drives the pins and short erase times.
`timescale 1ns/10ps
`include "flash_erase_defines.vh"
module testbench;
   logic        clk_sys_in = 0, rst_n_in = 0, ce_in = 1;
   logic        qpm = 0, wide = 0, ext = 0, dpd = 0, psel = 0, bph = 0, psl = 0, dsl = 0;
   wire         cs_n, sclk, write_in_progress, write_enable_latch, rej, start;
   wire  [3:0]  sio;
   wire  [31:0] base, ca;
   wire  [2:0]  kind;
   int          fail_count = 0, tests_run = 0;
   logic [7:0]  op_t [7] = '{`OP_SECTOR_ERASE, `OP_HALF_BLOCK_ERASE, `OP_BLOCK_ERASE,
      `OP_SECTOR_ERASE_WIDE, `OP_HALF_BLOCK_ERASE_WIDE, `OP_BLOCK_ERASE_WIDE, `OP_BLOCK_ERASE};
   logic [31:0] a_t [7] = '{32'h00123ABC, 32'h00FFFFFF, 32'h00345678, 32'hAB123FFF,
      32'h80007FFF, 32'hFFFF0001, 32'h12345678};
   logic [2:0]  k_t [7] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h4, 3'h4};
   logic [6:0]  q_v = 7'h12, e_v = 7'h02, w_v = 7'h40;
   logic [3:0]  p_t [4] = '{4'h4, 4'hA, 4'h9, 4'hC};
   always #5 clk_sys_in = ~clk_sys_in;
   flash_host_model host_u (.cs_n_out(cs_n), .sclk_out(sclk), .sio_out(sio));
   serial_flash_erase_commands #(.SECTOR_ERASE_CYCLES(2000), .HALF_BLOCK_ERASE_CYCLES(3000),
      .BLOCK_ERASE_CYCLES(4000)) dut_u (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .cs_n_in(cs_n), .sclk_in(sclk),
      .sio_in(sio), .quad_peripheral_mode_in(qpm), .wide_address_mode_in(wide),
      .extended_address_bit_in(ext), .deep_power_down_in(dpd), .protect_select_in(psel),
      .block_protect_hit_in(bph), .persistent_sector_lock_in(psl), .dynamic_sector_lock_in(dsl),
      .check_addr_out(ca), .write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch),
      .erase_reject_out(rej), .erase_start_out(start), .erase_base_addr_out(base),
      .erase_kind_out(kind));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic write_enable_cmd(input logic q);
      host_u.send_frame({32'h0, `OP_WRITE_ENABLE}, 8, q);
      repeat (10) @(posedge clk_sys_in);
      #1;
   endtask
   // Answer: 0 none, 1 start, 2 reject; pulses stand one cycle
   task automatic erase_case(input logic [39:0] f, input int n, input logic q, input logic [1:0] exp,
                             input logic [31:0] eb, input logic [2:0] ek);
      logic [1:0]  got;
      logic [31:0] b;
      logic [2:0]  k;
      got = 2'h0;
      b = 32'h0;
      k = 3'h0;
      host_u.send_frame(f, n, q);
      repeat (20) begin
         @(posedge clk_sys_in);
         #1;
         if (start === 1'b1) begin
            got = 2'h1;
            b = base;
            k = kind;
         end
         if (rej === 1'b1)
            got = 2'h2;
      end
      chk("answer", exp, got);
      if (exp == 2'h1) begin
         chk("base", eb, b);
         chk("kind", ek, k);
         chk("check addr", eb, ca);
      end
   endtask
   task automatic wait_done;
      int t;
      t = 0;
      while (write_in_progress === 1'b1 && t < 6000) begin
         @(posedge clk_sys_in);
         #1;
         t++;
      end
      chk("busy end", 0, write_in_progress);
      chk("latch end", 0, write_enable_latch);
   endtask
   initial begin
      int          n, lsb;
      logic [31:0] ea;
      logic [39:0] f;
      repeat (3) @(posedge clk_sys_in);
      #1 rst_n_in = 1;
      repeat (5) @(posedge clk_sys_in);
      #1;
      for (int i = 0; i < 7; i++) begin
         qpm = q_v[i];
         ext = e_v[i];
         wide = w_v[i];
         n = (i >= 3) ? 40 : 32;
         ea = (n == 40) ? a_t[i] : {7'h00, e_v[i], a_t[i][23:0]};
         lsb = (k_t[i] == 3'h1) ? `SECTOR_LSB : (k_t[i] == 3'h2) ? `HALF_BLOCK_LSB : `BLOCK_LSB;
         f = (n == 40) ? {op_t[i], a_t[i]} : {8'h00, op_t[i], a_t[i][23:0]};
         write_enable_cmd(qpm);
         chk("latch set", 1, write_enable_latch);
         erase_case(f, n, qpm, 2'h1, (ea >> lsb) << lsb, k_t[i]);
         chk("busy", 1, write_in_progress);
         if (i == 0) begin
            write_enable_cmd(qpm);
            erase_case(f, n, qpm, 2'h0, 32'h0, 3'h0);
            chk("busy kept", 1, write_in_progress);
         end
         wait_done;
         $display("erase case %0d done", i);
      end
      qpm = 0;
      ext = 0;
      wide = 0;
      write_enable_cmd(0);
      erase_case({8'h00, `OP_SECTOR_ERASE, 24'h001000} >> 1, 31, 0, 2'h2, 0, 0);
      erase_case({7'h00, `OP_SECTOR_ERASE, 24'h001000, 1'b0}, 33, 0, 2'h2, 0, 0);
      chk("latch kept", 1, write_enable_latch);
      $display("length test done");
      for (int j = 0; j < 4; j++) begin
         {psel, bph, psl, dsl} = p_t[j];
         erase_case({8'h00, `OP_BLOCK_ERASE, 24'h020000}, 32, 0, (j == 3) ? 2'h1 : 2'h2, 32'h00020000, 3'h4);
      end
      wait_done;
      {psel, bph, psl, dsl} = 4'h0;
      $display("protection test done");
      erase_case({8'h00, `OP_SECTOR_ERASE, 24'h000000}, 32, 0, 2'h2, 0, 0);
      write_enable_cmd(0);
      dpd = 1;
      repeat (4) @(posedge clk_sys_in);
      #1;
      erase_case({8'h00, `OP_SECTOR_ERASE, 24'h000000}, 32, 0, 2'h0, 0, 0);
      chk("busy asleep", 0, write_in_progress);
      dpd = 0;
      $display("latch and sleep test done");
      complete_run;
   end
   initial begin
      #1000000;
      fail_count++;
      complete_run;
   end
endmodule

// File: inc/flash_erase_defines.vh
// Constants for the serial flash erase command block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef FLASH_ERASE_DEFINES_VH
`define FLASH_ERASE_DEFINES_VH

// Clock rate
`define CLK_MHZ                 100

// Opcodes
`define OP_WRITE_ENABLE         8'h06
`define OP_SECTOR_ERASE         8'h20
`define OP_HALF_BLOCK_ERASE     8'h52
`define OP_BLOCK_ERASE          8'hD8
`define OP_SECTOR_ERASE_WIDE    8'h21
`define OP_HALF_BLOCK_ERASE_WIDE 8'h5C
`define OP_BLOCK_ERASE_WIDE     8'hDC

// Frame lengths in bits
`define OPCODE_BITS             6'h08
`define NARROW_FRAME_BITS       6'h20
`define WIDE_FRAME_BITS         6'h28
`define FRAME_BITS_MAX          6'h3F

// Lowest address bit that selects each erase unit
`define SECTOR_LSB              12
`define HALF_BLOCK_LSB          15
`define BLOCK_LSB               16

// Extended address bit position in narrow addressing
`define EXT_ADDR_POS            24

// Erase kinds, one-hot
`define KIND_SECTOR             3'h1
`define KIND_HALF_BLOCK         3'h2
`define KIND_BLOCK              3'h4

// Erase times in microseconds
`define SECTOR_ERASE_TIME_US     45000
`define HALF_BLOCK_ERASE_TIME_US 250000
`define BLOCK_ERASE_TIME_US      500000

// Erase times in system clock cycles
`define SECTOR_ERASE_CYCLES     (`SECTOR_ERASE_TIME_US * `CLK_MHZ)
`define HALF_BLOCK_ERASE_CYCLES (`HALF_BLOCK_ERASE_TIME_US * `CLK_MHZ)
`define BLOCK_ERASE_CYCLES      (`BLOCK_ERASE_TIME_US * `CLK_MHZ)

`endif

// File: verilog/erase_timer.v
// Self-timed erase cycle counter.
// Assumes start pulses only while idle; clock enable freezes it.
`timescale 1ns/10ps
module erase_timer #(
   parameter CNT_W = 32
) (
   // Clock and reset
   input  wire             clk_sys_in,
   input  wire             rst_n_in,
   input  wire             ce_in,
   // Control
   input  wire             start_in,
   input  wire [CNT_W-1:0] cycles_in,
   // Status
   output wire             busy_out,
   output reg              done_out
);

   reg [CNT_W-1:0] count_reg;
   reg             busy_reg;

   assign busy_out = busy_reg;

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         count_reg <= {CNT_W{1'b0}};
         busy_reg  <= 1'b0;
         done_out  <= 1'b0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         if (start_in && !busy_reg) begin
            count_reg <= cycles_in;
            busy_reg  <= 1'b1;
         end else if (busy_reg) begin
            // Count of one or zero both end after the current cycle
            if (count_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
               busy_reg <= 1'b0;
               done_out <= 1'b1;
            end else begin
               count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

// File: verilog/serial_flash_erase_commands.v
// Erase command handling of a serial NOR flash: sector, half block, block.
// Assumes pins come from another domain; protection lookup answers
// check_addr_out combinationally on the same clock; the array performs
// the erase named by erase_start_out, erase_base_addr_out, erase_kind_out.
//
// Function
// RULE1 - Sector erase sets every bit of addressed 4K-byte sector, nothing else.
// RULE2 - Host issues write enable before any erase command.
// RULE3 - Sector chosen by address bit 12 upward; lower bits ignored.
// RULE4 - Select must rise right after last address bit, else erase rejected.
// RULE5 - Host sends select low, opcode, 3 or 4 address bytes, select high.
// RULE6 - Opcode accepted as 8 clocks single-line or 2 clocks quad.
// RULE7 - Single-line mode ignores the upper three data lines.
// RULE8 - Erase cycle starts right when select rises after valid command.
// RULE9 - Write-in-progress high during erase; clears with write enable latch at end.
// RULE10 - Status stays readable while erase runs.
// RULE11 - Protected targets not erased; protect select picks which protection applies.
// RULE12 - Half-block erase clears 32K-byte block chosen by bit 15 upward.
// RULE13 - Block erase clears 64K-byte block, any address inside accepted.
// RULE14 - Three-byte addresses by default; wide mode or extended bit reach higher.
// RULE15 - Wide erase opcodes always take four address bytes.
// RULE16 - Deep power-down ignores all erase commands.
// RULE17 - Clear write enable latch at completion discards the command.
// RULE18 - Erase commands during a running erase are ignored.
`timescale 1ns/10ps
`include "flash_erase_defines.vh"
module serial_flash_erase_commands #(
   parameter CNT_W                   = 32,
   parameter SECTOR_ERASE_CYCLES     = `SECTOR_ERASE_CYCLES,
   parameter HALF_BLOCK_ERASE_CYCLES = `HALF_BLOCK_ERASE_CYCLES,
   parameter BLOCK_ERASE_CYCLES      = `BLOCK_ERASE_CYCLES
) (
   // Clock, reset, enable
   input  wire        clk_sys_in,
   input  wire        rst_n_in,
   input  wire        ce_in,
   // Serial pins from the host
   input  wire        cs_n_in,
   input  wire        sclk_in,
   input  wire [3:0]  sio_in,
   // Mode and protection state
   input  wire        quad_peripheral_mode_in,
   input  wire        wide_address_mode_in,
   input  wire        extended_address_bit_in,
   input  wire        deep_power_down_in,
   input  wire        protect_select_in,
   input  wire        block_protect_hit_in,
   input  wire        persistent_sector_lock_in,
   input  wire        dynamic_sector_lock_in,
   // Protection lookup address
   output wire [31:0] check_addr_out,
   // Status
   output wire        write_in_progress_out,
   output wire        write_enable_latch_out,
   output reg         erase_reject_out,
   // Array erase request
   output reg         erase_start_out,
   output reg  [31:0] erase_base_addr_out,
   output reg  [2:0]  erase_kind_out
);

   localparam ST_IDLE  = 3'h1;
   localparam ST_CHECK = 3'h2;
   localparam ST_BUSY  = 3'h4;

   // Clear address bits below the erase unit
   function [31:0] unit_base;
      input [31:0] addr;
      input [2:0]  kind;
      begin
         case (kind)
            `KIND_SECTOR:     unit_base = addr & ~((32'h1 << `SECTOR_LSB) - 32'h1);
            `KIND_HALF_BLOCK: unit_base = addr & ~((32'h1 << `HALF_BLOCK_LSB) - 32'h1);
            default:          unit_base = addr & ~((32'h1 << `BLOCK_LSB) - 32'h1);
         endcase
      end
   endfunction

   // Decode an opcode into kind and wide flag; zero kind means not an erase
   function [3:0] decode_op;
      input [7:0] op;
      begin
         case (op)
            `OP_SECTOR_ERASE:          decode_op = {1'b0, `KIND_SECTOR};
            `OP_HALF_BLOCK_ERASE:      decode_op = {1'b0, `KIND_HALF_BLOCK};
            `OP_BLOCK_ERASE:           decode_op = {1'b0, `KIND_BLOCK};
            `OP_SECTOR_ERASE_WIDE:     decode_op = {1'b1, `KIND_SECTOR};
            `OP_HALF_BLOCK_ERASE_WIDE: decode_op = {1'b1, `KIND_HALF_BLOCK};
            `OP_BLOCK_ERASE_WIDE:      decode_op = {1'b1, `KIND_BLOCK};
            default:                   decode_op = 4'h0;
         endcase
      end
   endfunction

   // Pin synchronisers: first stage read only by the second
   reg        cs_n_s1_reg;
   reg        cs_n_s2_reg;
   reg        cs_n_d_reg;
   reg        sclk_s1_reg;
   reg        sclk_s2_reg;
   reg        sclk_d_reg;
   reg  [3:0] sio_s1_reg;
   reg  [3:0] sio_s2_reg;

   reg  [39:0] shift_reg;
   reg  [7:0]  op_reg;
   reg  [5:0]  bit_cnt_reg;
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg         wel_reg;
   reg  [31:0] target_addr_reg;
   reg  [2:0]  target_kind_reg;
   reg  [CNT_W-1:0] erase_cycles;

   wire sclk_rise = sclk_s2_reg & ~sclk_d_reg;
   wire cs_rise   = cs_n_s2_reg & ~cs_n_d_reg;
   wire cs_fall   = ~cs_n_s2_reg & cs_n_d_reg;

   wire        timer_done;

   // Frame fields at select rise
   // Opcode kept from the first byte, so a frame of wrong length is still known
   wire [7:0]  frame_op   = op_reg;
   wire [3:0]  op_info    = decode_op(frame_op);
   wire        op_wide    = op_info[3];
   wire [2:0]  op_kind    = op_info[2:0];
   wire        long_addr  = op_wide | wide_address_mode_in;                      // RULE15 RULE14
   wire [5:0]  need_bits  = long_addr ? `WIDE_FRAME_BITS : `NARROW_FRAME_BITS;
   wire [31:0] narrow_adr = {7'h00, extended_address_bit_in, shift_reg[23:0]};   // RULE14
   wire [31:0] frame_addr = long_addr ? shift_reg[31:0] : narrow_adr;
   wire        erase_frame = (op_kind != 3'h0) && (bit_cnt_reg == need_bits);   // RULE4 RULE5
   wire        write_enable_cmd_frame  = (bit_cnt_reg == `OPCODE_BITS) && (shift_reg[7:0] == `OP_WRITE_ENABLE);
   wire        idle        = (state_reg == ST_IDLE);

   assign check_addr_out         = target_addr_reg;
   assign write_in_progress_out  = (state_reg != ST_IDLE);                       // RULE9 RULE10
   assign write_enable_latch_out = wel_reg;

   always @* begin
      case (target_kind_reg)
         `KIND_SECTOR:     erase_cycles = SECTOR_ERASE_CYCLES[CNT_W-1:0];
         `KIND_HALF_BLOCK: erase_cycles = HALF_BLOCK_ERASE_CYCLES[CNT_W-1:0];
         default:          erase_cycles = BLOCK_ERASE_CYCLES[CNT_W-1:0];
      endcase
   end

   // Protection gate uses the lookup answer for the latched target
   wire target_locked = protect_select_in ? (persistent_sector_lock_in | dynamic_sector_lock_in)
                                          : block_protect_hit_in;                 // RULE11

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (cs_rise && erase_frame && wel_reg && !deep_power_down_in)        // RULE17 RULE16
               state_next = ST_CHECK;                                             // RULE8
         end
         ST_CHECK: begin
            if (target_locked)
               state_next = ST_IDLE;                                              // RULE11
            else
               state_next = ST_BUSY;
         end
         ST_BUSY: begin
            if (timer_done)
               state_next = ST_IDLE;                                              // RULE9
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cs_n_s1_reg <= 1'b1;
         cs_n_s2_reg <= 1'b1;
         cs_n_d_reg  <= 1'b1;
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_d_reg  <= 1'b0;
         sio_s1_reg  <= 4'h0;
         sio_s2_reg  <= 4'h0;
      end else if (ce_in) begin
         cs_n_s1_reg <= cs_n_in;
         cs_n_s2_reg <= cs_n_s1_reg;
         cs_n_d_reg  <= cs_n_s2_reg;
         sclk_s1_reg <= sclk_in;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_d_reg  <= sclk_s2_reg;
         sio_s1_reg  <= sio_in;
         sio_s2_reg  <= sio_s1_reg;
      end
   end

   // Frame shifter; counter saturates so overlong frames never match
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         shift_reg   <= 40'h0;
         bit_cnt_reg <= 6'h00;
         op_reg      <= 8'h00;
      end else if (ce_in) begin
         if (cs_fall) begin
            shift_reg   <= 40'h0;
            bit_cnt_reg <= 6'h00;
            op_reg      <= 8'h00;
         end else if (!cs_n_s2_reg && sclk_rise) begin
            if (quad_peripheral_mode_in) begin
               shift_reg <= {shift_reg[35:0], sio_s2_reg};                       // RULE6
               if (bit_cnt_reg == `OPCODE_BITS - 6'h04)
                  op_reg <= {shift_reg[3:0], sio_s2_reg};                        // RULE6
               if (bit_cnt_reg <= `FRAME_BITS_MAX - 6'h04)
                  bit_cnt_reg <= bit_cnt_reg + 6'h04;
               else
                  bit_cnt_reg <= `FRAME_BITS_MAX;
            end else begin
               shift_reg <= {shift_reg[38:0], sio_s2_reg[0]};                    // RULE6 RULE7
               if (bit_cnt_reg == `OPCODE_BITS - 6'h01)
                  op_reg <= {shift_reg[6:0], sio_s2_reg[0]};                     // RULE6 RULE7
               if (bit_cnt_reg != `FRAME_BITS_MAX)
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
         end
      end
   end

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_reg           <= ST_IDLE;
         wel_reg             <= 1'b0;
         target_addr_reg     <= 32'h0;
         target_kind_reg     <= `KIND_BLOCK;
         erase_start_out     <= 1'b0;
         erase_reject_out    <= 1'b0;
         erase_base_addr_out <= 32'h0;
         erase_kind_out      <= 3'h0;
      end else if (ce_in) begin
         state_reg        <= state_next;
         erase_start_out  <= 1'b0;
         erase_reject_out <= 1'b0;
         if (idle && cs_rise) begin
            if (erase_frame && wel_reg && !deep_power_down_in) begin
               target_addr_reg <= unit_base(frame_addr, op_kind);                // RULE3 RULE12 RULE13
               target_kind_reg <= op_kind;
            end else if (op_kind != 3'h0 && !deep_power_down_in) begin
               erase_reject_out <= 1'b1;                                          // RULE4 RULE17
            end
            // Write enable ignored in deep power-down and while busy
            if (write_enable_cmd_frame && !deep_power_down_in)
               wel_reg <= 1'b1;
         end
         if (state_reg == ST_CHECK) begin
            if (target_locked) begin
               erase_reject_out <= 1'b1;                                          // RULE11
            end else begin
               erase_start_out     <= 1'b1;                                       // RULE1 RULE12 RULE13
               erase_base_addr_out <= target_addr_reg;
               erase_kind_out      <= target_kind_reg;
            end
         end
         if (state_reg == ST_BUSY && timer_done)
            wel_reg <= 1'b0;                                                      // RULE9
      end
   end

   // Running erase owns the timer; later commands never reach it
   erase_timer #(
      .CNT_W      (CNT_W)
   ) u_timer (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .start_in   ((state_reg == ST_CHECK) && !target_locked),                    // RULE18
      .cycles_in  (erase_cycles),
      .busy_out   (),
      .done_out   (timer_done)
   );

endmodule
